/* common/oeim_pkg.sv */
// package for the event and iso channel mask register block
// assumes a 32-bit register port with byte offsets
package oeim_pkg;
	localparam logic [7:0] OEIM_CHMASK_SET_OFS = 8'h78;
	localparam logic [7:0] OEIM_CHMASK_CLR_OFS = 8'h7c;
	localparam logic [7:0] OEIM_EVENT_SET_OFS = 8'h80;
	localparam logic [7:0] OEIM_EVENT_CLR_OFS = 8'h84;
	localparam logic [7:0] OEIM_EVMASK_OFS = 8'h88;
	localparam logic [7:0] OEIM_CTRL_OFS = 8'h8c;
	localparam logic [7:0] OEIM_STATUS_OFS = 8'h90;
	localparam logic [7:0] OEIM_IRQMASK_OFS = 8'h94;
	localparam int OEIM_GPIO_BIT = 30;
	localparam int OEIM_SOFT_BIT = 29;
	localparam int OEIM_TARDY_BIT = 27;
	localparam int OEIM_PHYREG_BIT = 26;
	localparam int OEIM_LONG_BIT = 25;
	localparam int OEIM_FATAL_BIT = 24;
	localparam int OEIM_MISMATCH_BIT = 23;
	// implemented event bits: 30,29,27..23
	localparam logic [31:0] OEIM_EVENT_IMPL = 32'h6f80_0000;
	localparam logic [31:0] OEIM_EVENT_RST = 32'h0000_0000;
	localparam logic [31:0] OEIM_CHMASK_RST = 32'h0000_0000;
	localparam logic [31:0] OEIM_EVMASK_RST = 32'h0000_0000;
	// control register fields
	localparam int OEIM_CTRL_GPA_EN = 0;
	localparam int OEIM_CTRL_GPB_EN = 1;
	localparam int OEIM_CTRL_LATE_EN = 2;
	localparam int OEIM_CTRL_ROOT = 3;
	localparam logic [3:0] OEIM_CTRL_RST = 4'h0;
	// cycle limit 125 us at 25 MHz
	localparam int OEIM_CLK_MHZ = 25;
	localparam int OEIM_CYCLE_LIMIT_US = 125;
	localparam int OEIM_CYCLE_LIMIT_CYC = OEIM_CYCLE_LIMIT_US * OEIM_CLK_MHZ;
	localparam int OEIM_IRQ_W = 2;
	localparam int OEIM_IRQ_EVENT = 0;
	localparam int OEIM_IRQ_CHMASK = 1;
endpackage : oeim_pkg

/* src/oeim_regs.sv */
// event register, lower iso channel mask, control and interrupt logic
// assumes synchronous inputs on CLOCK and a single-cycle register port
//
// Function
// [RQ1] accept iso channel n packets only while mask bit n is one
// [RQ2] mask: ones at set address set bits, ones at clear address clear
// [RQ3] event bit set on source rising edge or software set write
// [RQ4] event bit cleared only by one written at clear address
// [RQ5] event read returns latched events ANDed with event mask
// [RQ6] event bits 31 and 28 read zero, ignore writes
// [RQ7] bit 30 set when an enabled general-purpose input asserts
// [RQ8] bit 29 is a software-only interrupt set via set address
// [RQ9] bit 27 set on late-ack causes while late-ack enable is one
// [RQ10] bit 26 set when a phy register byte arrives
// [RQ11] bit 25 set when cycle exceeds 125 us as timing root
// [RQ12] overlong cycle also clears the timing root role bit
// [RQ13] bit 24 set on any error halting subunits
// [RQ14] while bit 24 set, offending contexts' normal interrupts are blocked
// [RQ15] bit 23 set when received cycle start differs from cycle timer
// [RQ16] event bits 14 to 10 read zero
// [RQ17] zero bits in set or clear writes leave bits unchanged
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module oeim_regs
	import oeim_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic IRQ,
	input wire logic GP_IRQ_A,
	input wire logic GP_IRQ_B,
	input wire logic RX_FIFO_PENDING,
	input wire logic RESP_UNIT_BUSY,
	input wire logic LATE_ACK_SENT,
	input wire logic PHY_REG_BYTE_ARRIVED,
	input wire logic CYCLE_START_TX,
	input wire logic SUBACTION_GAP_END,
	input wire logic SUBUNIT_HALT,
	input wire logic CYCLE_START_RX,
	input wire logic [6:0] RX_SECONDS,
	input wire logic [12:0] RX_TICKS,
	input wire logic [6:0] TIMER_SECOND_FIELD,
	input wire logic [12:0] TIMER_TICK_FIELD,
	input wire logic [5:0] ISO_RX_CHANNEL,
	input wire logic ISO_RX_VALID,
	output logic ISO_RX_ACCEPT,
	output logic TIMING_ROOT_ROLE,
	output logic CONTEXT_IRQ_BLOCK
);
	logic [31:0] chmask_r;
	logic [31:0] event_r;
	logic [31:0] evmask_r;
	logic [3:0] ctrl_r;
	logic [OEIM_IRQ_W-1:0] irq_stat_r;
	logic [OEIM_IRQ_W-1:0] irq_mask_r;
	logic [31:0] src_r;
	logic [31:0] src_nxt;
	logic [31:0] rise;
	logic [11:0] cyc_cnt_r;
	logic cyc_run_r;
	logic overlong;
	logic wr_ev_set;
	logic wr_ev_clr;
	logic wr_ch_set;
	logic wr_ch_clr;
	logic [31:0] event_nxt;
	logic [31:0] chmask_nxt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
		hit = s && (a == ofs);
	endfunction : hit

	assign wr_ev_set = hit(ADDR, OEIM_EVENT_SET_OFS, WR);
	assign wr_ev_clr = hit(ADDR, OEIM_EVENT_CLR_OFS, WR);
	assign wr_ch_set = hit(ADDR, OEIM_CHMASK_SET_OFS, WR);
	assign wr_ch_clr = hit(ADDR, OEIM_CHMASK_CLR_OFS, WR);

	// overlong cycle timer, runs only while timing root
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cyc_cnt_r <= 12'h000;
			cyc_run_r <= 1'b0;
		end
		else if (!ctrl_r[OEIM_CTRL_ROOT] || SUBACTION_GAP_END || overlong)
		begin
			cyc_cnt_r <= 12'h000;
			cyc_run_r <= 1'b0;
		end
		else if (CYCLE_START_TX && !cyc_run_r)
		begin
			cyc_cnt_r <= 12'h001;
			cyc_run_r <= 1'b1;
		end
		else if (cyc_run_r)
		begin
			cyc_cnt_r <= cyc_cnt_r + 12'h001;
		end
	end

	assign overlong = ctrl_r[OEIM_CTRL_ROOT] && cyc_run_r
		&& (cyc_cnt_r > 12'(OEIM_CYCLE_LIMIT_CYC)); // RQ11

	// source levels, edge detected below
	always_comb
	begin
		src_nxt = 32'h0000_0000;
		src_nxt[OEIM_GPIO_BIT] = (GP_IRQ_A && ctrl_r[OEIM_CTRL_GPA_EN])
			|| (GP_IRQ_B && ctrl_r[OEIM_CTRL_GPB_EN]); // RQ7
		src_nxt[OEIM_TARDY_BIT] = ctrl_r[OEIM_CTRL_LATE_EN]
			&& (RX_FIFO_PENDING || RESP_UNIT_BUSY || LATE_ACK_SENT); // RQ9
		src_nxt[OEIM_PHYREG_BIT] = PHY_REG_BYTE_ARRIVED; // RQ10
		src_nxt[OEIM_LONG_BIT] = overlong; // RQ11
		src_nxt[OEIM_FATAL_BIT] = SUBUNIT_HALT; // RQ13
		src_nxt[OEIM_MISMATCH_BIT] = CYCLE_START_RX
			&& ((RX_SECONDS != TIMER_SECOND_FIELD) || (RX_TICKS != TIMER_TICK_FIELD)); // RQ15
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			src_r <= 32'h0000_0000;
		else
			src_r <= src_nxt;
	end

	assign rise = src_nxt & ~src_r; // RQ3

	// set wins over clear; only implemented bits ever hold a one
	always_comb
	begin
		event_nxt = event_r;
		if (wr_ev_clr)
			event_nxt = event_nxt & ~WDATA; // RQ4 RQ17
		event_nxt = (event_nxt | rise | (wr_ev_set ? WDATA : 32'h0000_0000))
			& OEIM_EVENT_IMPL; // RQ3 RQ6 RQ8 RQ16
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			event_r <= OEIM_EVENT_RST;
		else
			event_r <= event_nxt;
	end

	always_comb
	begin
		chmask_nxt = chmask_r;
		if (wr_ch_set)
			chmask_nxt = chmask_nxt | WDATA; // RQ2 RQ17
		if (wr_ch_clr)
			chmask_nxt = chmask_nxt & ~WDATA; // RQ2 RQ17
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			chmask_r <= OEIM_CHMASK_RST;
		else
			chmask_r <= chmask_nxt;
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			evmask_r <= OEIM_EVMASK_RST;
		else if (hit(ADDR, OEIM_EVMASK_OFS, WR))
			evmask_r <= WDATA;
	end

	// control: overlong cycle drops the timing root role
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			ctrl_r <= OEIM_CTRL_RST;
		else
		begin
			if (hit(ADDR, OEIM_CTRL_OFS, WR))
				ctrl_r <= WDATA[3:0];
			// a write in the same cycle keeps its enables but loses the role
			if (overlong)
				ctrl_r[OEIM_CTRL_ROOT] <= 1'b0; // RQ12
		end
	end

	// block-level interrupt: any newly set event bit, any channel mask write
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end
		else
		begin
			if (hit(ADDR, OEIM_IRQMASK_OFS, WR))
				irq_mask_r <= WDATA[OEIM_IRQ_W-1:0];
			irq_stat_r <= (irq_stat_r & ~(hit(ADDR, OEIM_STATUS_OFS, WR)
				? WDATA[OEIM_IRQ_W-1:0] : '0))
				| {(wr_ch_set || wr_ch_clr), |(event_nxt & ~event_r)};
		end
	end

	assign IRQ = |(irq_stat_r & irq_mask_r);

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			RDATA <= 32'h0000_0000;
		else if (!RD)
			RDATA <= 32'h0000_0000;
		else
			case (ADDR)
				OEIM_CHMASK_SET_OFS, OEIM_CHMASK_CLR_OFS: RDATA <= chmask_r; // RQ2
				OEIM_EVENT_SET_OFS, OEIM_EVENT_CLR_OFS: RDATA <= event_r & evmask_r; // RQ5
				OEIM_EVMASK_OFS: RDATA <= evmask_r;
				OEIM_CTRL_OFS: RDATA <= {28'h000_0000, ctrl_r};
				OEIM_STATUS_OFS: RDATA <= {30'h0000_0000, irq_stat_r};
				OEIM_IRQMASK_OFS: RDATA <= {30'h0000_0000, irq_mask_r};
				default: RDATA <= 32'h0000_0000;
			endcase
	end

	assign ISO_RX_ACCEPT = ISO_RX_VALID && !ISO_RX_CHANNEL[5]
		&& chmask_r[ISO_RX_CHANNEL[4:0]]; // RQ1
	assign TIMING_ROOT_ROLE = ctrl_r[OEIM_CTRL_ROOT];
	assign CONTEXT_IRQ_BLOCK = event_r[OEIM_FATAL_BIT]; // RQ14

	// event register contents
	reserved_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ6 RQ16
		(event_r[31] == 1'b0) && (event_r[28] == 1'b0) && (event_r[14:10] == 5'h00))
		else $error("reserved event bit set");
	impl_only_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ6 RQ16
		(event_r & ~OEIM_EVENT_IMPL) == 32'h0000_0000)
		else $error("unimplemented event bit set");
	sticky_event_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ4
		!wr_ev_clr |=> (event_r & $past(event_r)) == $past(event_r))
		else $error("event cleared without clear write");
	clear_event_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ4
		wr_ev_clr && !wr_ev_set |=>
		((event_r & $past(WDATA) & ~$past(rise)) == 32'h0000_0000))
		else $error("clear write did not clear");
	event_zero_bits_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ17
		wr_ev_set || wr_ev_clr |=> (event_r & ~$past(WDATA))
		== (($past(event_r) | $past(rise)) & ~$past(WDATA)))
		else $error("zero bits of event write changed bits");
	set_write_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ3
		wr_ev_set |=> (event_r & $past(WDATA) & OEIM_EVENT_IMPL)
		== ($past(WDATA) & OEIM_EVENT_IMPL))
		else $error("event set write lost");
	rise_latch_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ3
		(rise != 32'h0000_0000) |=> (event_r & $past(rise)) == $past(rise))
		else $error("source edge not latched");
	soft_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ8
		wr_ev_set && WDATA[OEIM_SOFT_BIT] |=> event_r[OEIM_SOFT_BIT])
		else $error("software set lost");
	soft_only_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ8
		!event_r[OEIM_SOFT_BIT] && !wr_ev_set |=> !event_r[OEIM_SOFT_BIT])
		else $error("software bit set by hardware");

	// event sources
	gpio_a_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ7
		GP_IRQ_A && ctrl_r[OEIM_CTRL_GPA_EN] && !src_r[OEIM_GPIO_BIT]
		|=> event_r[OEIM_GPIO_BIT])
		else $error("gpio input a edge lost");
	gpio_b_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ7
		GP_IRQ_B && ctrl_r[OEIM_CTRL_GPB_EN] && !src_r[OEIM_GPIO_BIT]
		|=> event_r[OEIM_GPIO_BIT])
		else $error("gpio input b edge lost");
	gpio_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ7
		!ctrl_r[OEIM_CTRL_GPA_EN] && !ctrl_r[OEIM_CTRL_GPB_EN] |-> !rise[OEIM_GPIO_BIT])
		else $error("gpio event while disabled");
	late_ack_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ9
		ctrl_r[OEIM_CTRL_LATE_EN] && (RX_FIFO_PENDING || RESP_UNIT_BUSY || LATE_ACK_SENT)
		&& !src_r[OEIM_TARDY_BIT] |=> event_r[OEIM_TARDY_BIT])
		else $error("late ack event lost");
	late_ack_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ9
		!ctrl_r[OEIM_CTRL_LATE_EN] |-> !rise[OEIM_TARDY_BIT])
		else $error("late ack event while disabled");
	phy_byte_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ10
		PHY_REG_BYTE_ARRIVED && !src_r[OEIM_PHYREG_BIT] |=> event_r[OEIM_PHYREG_BIT])
		else $error("phy register byte event lost");
	fatal_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ13
		SUBUNIT_HALT && !src_r[OEIM_FATAL_BIT] |=> event_r[OEIM_FATAL_BIT])
		else $error("fatal error event lost");
	ctx_block_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ14
		CONTEXT_IRQ_BLOCK == event_r[OEIM_FATAL_BIT])
		else $error("context interrupt block wrong");
	mismatch_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ15
		rise[OEIM_MISMATCH_BIT] |=> event_r[OEIM_MISMATCH_BIT])
		else $error("timer mismatch not latched");
	mismatch_equal_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ15
		CYCLE_START_RX && (RX_SECONDS == TIMER_SECOND_FIELD)
		&& (RX_TICKS == TIMER_TICK_FIELD) |-> !rise[OEIM_MISMATCH_BIT])
		else $error("mismatch flagged on matching cycle start");
	mismatch_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ15
		!CYCLE_START_RX |-> !rise[OEIM_MISMATCH_BIT])
		else $error("mismatch flagged without cycle start");

	// overlong cycle: arm on cycle start, count, then flag and drop the role
	sequence cyc_arm_seq;
		CYCLE_START_TX && ctrl_r[OEIM_CTRL_ROOT] && !cyc_run_r && !SUBACTION_GAP_END;
	endsequence
	sequence cyc_armed_seq;
		cyc_run_r && (cyc_cnt_r == 12'h001);
	endsequence
	sequence long_seq;
		overlong ##1 1'b1;
	endsequence
	cyc_arm_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		cyc_arm_seq |=> cyc_armed_seq)
		else $error("cycle timer did not arm");
	cyc_count_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		cyc_run_r && ctrl_r[OEIM_CTRL_ROOT] && !SUBACTION_GAP_END && !overlong
		|=> cyc_cnt_r == $past(cyc_cnt_r) + 12'h001)
		else $error("cycle timer did not count");
	early_long_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		(cyc_cnt_r <= 12'(OEIM_CYCLE_LIMIT_CYC)) |-> !overlong)
		else $error("overlong flagged before limit");
	gap_stop_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		SUBACTION_GAP_END |=> !cyc_run_r)
		else $error("gap end did not stop cycle timer");
	root_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		!TIMING_ROOT_ROLE |=> !cyc_run_r && !overlong)
		else $error("cycle timer ran without timing root role");
	root_drop_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11 RQ12
		long_seq |-> !TIMING_ROOT_ROLE && event_r[OEIM_LONG_BIT])
		else $error("overlong cycle mishandled");
	long_pulse_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ11
		overlong |=> !overlong)
		else $error("overlong held after flagging");

	// lower channel mask and iso accept
	mask_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ2
		wr_ch_set && !wr_ch_clr |=> (chmask_r & $past(WDATA)) == $past(WDATA))
		else $error("channel mask set failed");
	mask_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ2
		wr_ch_clr |=> (chmask_r & $past(WDATA)) == 32'h0000_0000)
		else $error("channel mask clear failed");
	mask_zero_bits_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ17
		wr_ch_set || wr_ch_clr |=> (chmask_r & ~$past(WDATA))
		== ($past(chmask_r) & ~$past(WDATA)))
		else $error("zero bits of mask write changed bits");
	mask_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ2
		!wr_ch_set && !wr_ch_clr |=> chmask_r == $past(chmask_r))
		else $error("channel mask changed without write");
	iso_accept_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ1
		ISO_RX_ACCEPT |-> ISO_RX_CHANNEL < 6'h20 && chmask_r[ISO_RX_CHANNEL[4:0]])
		else $error("channel accepted while disabled");
	iso_enable_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ1
		ISO_RX_VALID && !ISO_RX_CHANNEL[5] && chmask_r[ISO_RX_CHANNEL[4:0]]
		|-> ISO_RX_ACCEPT)
		else $error("enabled channel refused");
	iso_idle_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ1
		!ISO_RX_VALID |-> !ISO_RX_ACCEPT)
		else $error("accept without valid packet");

	// register port reads and block interrupt
	event_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ5
		RD && ((ADDR == OEIM_EVENT_SET_OFS) || (ADDR == OEIM_EVENT_CLR_OFS))
		|=> RDATA == ($past(event_r) & $past(evmask_r)))
		else $error("event read not masked");
	mask_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ2
		RD && ((ADDR == OEIM_CHMASK_SET_OFS) || (ADDR == OEIM_CHMASK_CLR_OFS))
		|=> RDATA == $past(chmask_r))
		else $error("channel mask read wrong");
	reserved_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RQ6 RQ16
		RD && ((ADDR == OEIM_EVENT_SET_OFS) || (ADDR == OEIM_EVENT_CLR_OFS))
		|=> (RDATA[31] == 1'b0) && (RDATA[28] == 1'b0) && (RDATA[14:10] == 5'h00))
		else $error("reserved event bit read as one");
	idle_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		!RD |=> RDATA == 32'h0000_0000)
		else $error("read data outside read cycle");
	irq_new_event_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		(event_nxt & ~event_r) != 32'h0000_0000 |=> irq_stat_r[OEIM_IRQ_EVENT])
		else $error("new event did not raise status");
endmodule : oeim_regs

/* verification/tb.sv */
// bench for the event and iso channel mask register block
// assumes oeim_regs answers reads one cycle after the read strobe
`timescale 1ns/1ps
module tb;
	import oeim_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0, rd_s = 1'b0, cs_tx = 1'b0, gap_end = 1'b0, cs_rx = 1'b0, iso_v = 1'b0;
	logic [6:0] hw = 7'h00;
	logic [6:0] rx_sec = 7'h05, tm_sec = 7'h05;
	logic [12:0] rx_tick = 13'h100, tm_tick = 13'h100;
	logic [5:0] iso_ch = 6'h00;
	logic [31:0] rdata;
	logic irq, acc, root, blk;
	int errors = 0;
	int cmp_count = 0;
	int bits[7] = '{30, 30, 27, 27, 27, 26, 24};
	int chans[5] = '{5, 0, 31, 32, 63};
	logic accs[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

	oeim_regs oeim_regs_i (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .IRQ(irq), .GP_IRQ_A(hw[0]), .GP_IRQ_B(hw[1]),
		.RX_FIFO_PENDING(hw[2]), .RESP_UNIT_BUSY(hw[3]), .LATE_ACK_SENT(hw[4]),
		.PHY_REG_BYTE_ARRIVED(hw[5]), .CYCLE_START_TX(cs_tx), .SUBACTION_GAP_END(gap_end),
		.SUBUNIT_HALT(hw[6]), .CYCLE_START_RX(cs_rx), .RX_SECONDS(rx_sec), .RX_TICKS(rx_tick),
		.TIMER_SECOND_FIELD(tm_sec), .TIMER_TICK_FIELD(tm_tick), .ISO_RX_CHANNEL(iso_ch),
		.ISO_RX_VALID(iso_v), .ISO_RX_ACCEPT(acc), .TIMING_ROOT_ROLE(root),
		.CONTEXT_IRQ_BLOCK(blk));

	initial forever #20 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd

	task automatic summarize;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (20000) @(posedge clock);
		errors++;
		summarize();
	end

	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rd(OEIM_EVENT_SET_OFS, 32'h0);
		wr(OEIM_CHMASK_SET_OFS, 32'h8000_0021);
		wr(OEIM_CHMASK_CLR_OFS, 32'h0000_0000);
		wr(OEIM_CHMASK_CLR_OFS, 32'h0000_0001);
		rd(OEIM_CHMASK_SET_OFS, 32'h8000_0020);
		rd(OEIM_CHMASK_CLR_OFS, 32'h8000_0020);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clock);
			iso_v <= 1'b1;
			iso_ch <= 6'(chans[i]);
			#1;
			chk({31'h0, acc}, {31'h0, accs[i]});
		end
		wr(OEIM_EVMASK_OFS, 32'hffff_ffff);
		wr(OEIM_EVENT_SET_OFS, 32'hffff_ffff);
		rd(OEIM_EVENT_SET_OFS, 32'h6f80_0000);
		wr(OEIM_EVENT_CLR_OFS, 32'h2000_0000);
		rd(OEIM_EVENT_CLR_OFS, 32'h4f80_0000);
		wr(OEIM_EVMASK_OFS, 32'h0100_0000);
		rd(OEIM_EVENT_SET_OFS, 32'h0100_0000);
		chk({31'h0, blk}, 32'h1);
		wr(OEIM_EVENT_CLR_OFS, 32'hffff_ffff);
		wr(OEIM_EVMASK_OFS, 32'hffff_ffff);
		chk({31'h0, blk}, 32'h0);
		// interrupt line: raise, mask, clear
		wr(OEIM_STATUS_OFS, 32'h3);
		wr(OEIM_EVENT_SET_OFS, 32'h2000_0000);
		chk({31'h0, irq}, 32'h0);
		rd(OEIM_STATUS_OFS, 32'h1);
		wr(OEIM_IRQMASK_OFS, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(OEIM_STATUS_OFS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(8'hfc, 32'h0);
		wr(OEIM_EVENT_CLR_OFS, 32'hffff_ffff);
		// gated sources set nothing while their enables are off and latch once enabled; phy and fatal always latch
		for (int e = 0; e < 2; e++)
		begin
			wr(OEIM_CTRL_OFS, (e > 0) ? 32'h7 : 32'h0);
			for (int i = 0; i < 7; i++)
			begin
				@(posedge clock);
				hw[i] <= 1'b1;
				repeat (2) @(posedge clock);
				hw[i] <= 1'b0;
				rd(OEIM_EVENT_SET_OFS, (e > 0 || i > 4) ? 32'h1 << bits[i] : 32'h0);
				rd(OEIM_EVENT_SET_OFS, (e > 0 || i > 4) ? 32'h1 << bits[i] : 32'h0);
				wr(OEIM_EVENT_CLR_OFS, 32'hffff_ffff);
			end
		end
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clock);
			rx_sec <= 7'h05 + 7'(i == 2);
			rx_tick <= 13'h100 + 13'(i == 1);
			cs_rx <= 1'b1;
			@(posedge clock);
			cs_rx <= 1'b0;
			rd(OEIM_EVENT_SET_OFS, (i > 0) ? 32'h0080_0000 : 32'h0);
			wr(OEIM_EVENT_CLR_OFS, 32'hffff_ffff);
		end
		// overlong cycle: once ended in time, once allowed to overrun
		wr(OEIM_CTRL_OFS, 32'h8);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			cs_tx <= 1'b1;
			@(posedge clock);
			cs_tx <= 1'b0;
			repeat (3090) @(posedge clock);
			gap_end <= (i == 0);
			@(posedge clock);
			gap_end <= 1'b0;
			rd(OEIM_EVENT_SET_OFS, 32'h0);
			repeat (60) @(posedge clock);
			rd(OEIM_EVENT_SET_OFS, (i > 0) ? 32'h0200_0000 : 32'h0);
			chk({31'h0, root}, (i > 0) ? 32'h0 : 32'h1);
		end
		// mid-run reset returns the registers to zero
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(OEIM_CHMASK_SET_OFS, 32'h0);
		rd(OEIM_EVMASK_OFS, 32'h0);
		rd(OEIM_STATUS_OFS, 32'h0);
		summarize();
	end
endmodule : tb
